/* design/anr_bank.sv */
// Negotiation status and low advertisement registers on the management port
`timescale 1ns/1ps
`include "anr_regs.svh"
module anr_bank
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [4:0] mgmt_dev_in,
	input wire logic [15:0] mgmt_addr_in,
	input wire logic mgmt_wr_in,
	input wire logic mgmt_rd_in,
	input wire anr_pkg::anr_word_t mgmt_wdata_in,
	output anr_pkg::anr_word_t mgmt_rdata_out,
	output logic mgmt_rvalid_out,
	input wire logic negotiation_enable_in,
	input wire logic negotiation_finished_in,
	input wire logic link_up_in,
	input wire logic codeword_captured_in,
	input wire logic base_page_in,
	input wire logic partner_fault_in,
	input wire logic codeword_ack_in,
	input wire logic role_advert_in,
	output logic next_page_request_out,
	output logic local_fault_advert_out,
	output logic role_force_select_out,
	output logic [1:0] pause_capability_out,
	output logic partner_page_valid_out,
	output logic [1:0] role_mode_out
);
	import anr_pkg::*;

	anr_latch_if lf();
	anr_sel_t sel;
	logic status_rd;
	logic advert_wr;
	logic codeword_ack;
	logic base_seen;
	logic negotiation_done_flag;
	anr_word_t negotiation_status_reg;
	anr_word_t local_advert_low_reg;

	////////////////////////////////////////////////////////////////////////////
	// Address decode within the negotiation device
	always_comb
	begin
		sel = ANR_SEL_NONE;
		if (mgmt_dev_in == `ANR_DEV_ADDR && mgmt_addr_in == `ANR_STATUS_OFS)
			sel = ANR_SEL_STATUS;
		else if (mgmt_dev_in == `ANR_DEV_ADDR && mgmt_addr_in == `ANR_ADVERT_OFS)
			sel = ANR_SEL_ADVERT;
	end

	assign status_rd = mgmt_rd_in && sel == ANR_SEL_STATUS;
	assign advert_wr = mgmt_wr_in && sel == ANR_SEL_ADVERT;

	////////////////////////////////////////////////////////////////////////////
	// Latched flags
	assign lf.status_read = status_rd;
	assign lf.page_event = codeword_captured_in;
	assign lf.fault_event = codeword_captured_in && base_page_in && partner_fault_in;
	assign lf.link_now = link_up_in;

	anr_latch_flags u_flags
	(
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.lf(lf)
	);

	// Partner base page valid once the first base page arrives in this negotiation
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in || !negotiation_enable_in)
			base_seen <= 1'b0;
		else if (codeword_captured_in && base_page_in)
			base_seen <= 1'b1;
	end

	assign partner_page_valid_out = base_seen;
	assign negotiation_done_flag = negotiation_enable_in && negotiation_finished_in
		&& link_up_in && base_seen;

	always_comb
	begin
		negotiation_status_reg = 16'h0000;
		negotiation_status_reg[`ANR_ST_PAGE_RX] = lf.page_received_flag;
		negotiation_status_reg[`ANR_ST_DONE] = negotiation_done_flag;
		negotiation_status_reg[`ANR_ST_FAULT] = lf.partner_fault_flag;
		negotiation_status_reg[`ANR_ST_CAPABLE] = 1'b1;
		negotiation_status_reg[`ANR_ST_LINK] = lf.latched_link_up_flag;
	end

	////////////////////////////////////////////////////////////////////////////
	// Low advertisement register
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			next_page_request_out <= 1'b0;
			local_fault_advert_out <= 1'b0;
			role_force_select_out <= 1'b0;
			pause_capability_out <= 2'h0;
		end
		else if (advert_wr)
		begin
			next_page_request_out <= mgmt_wdata_in[`ANR_AD_NEXT_PAGE];
			local_fault_advert_out <= mgmt_wdata_in[`ANR_AD_FAULT];
			role_force_select_out <= mgmt_wdata_in[`ANR_AD_FORCE];
			pause_capability_out <= mgmt_wdata_in[`ANR_AD_PAUSE_HI:`ANR_AD_PAUSE_LO];
		end
	end

	// Acknowledge follows the negotiation engine only
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			codeword_ack <= 1'b0;
		else
			codeword_ack <= codeword_ack_in;
	end

	// Role mode: bit1 forced, bit0 master
	assign role_mode_out = {role_force_select_out, role_advert_in};

	always_comb
	begin
		local_advert_low_reg = 16'h0000;
		local_advert_low_reg[`ANR_AD_NEXT_PAGE] = next_page_request_out;
		local_advert_low_reg[`ANR_AD_ACK] = codeword_ack;
		local_advert_low_reg[`ANR_AD_FAULT] = local_fault_advert_out;
		local_advert_low_reg[`ANR_AD_FORCE] = role_force_select_out;
		local_advert_low_reg[`ANR_AD_PAUSE_HI:`ANR_AD_PAUSE_LO] = pause_capability_out;
		local_advert_low_reg[4:0] = `ANR_SELECTOR;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			mgmt_rdata_out <= 16'h0000;
			mgmt_rvalid_out <= 1'b0;
		end
		else
		begin
			mgmt_rvalid_out <= mgmt_rd_in;
			// Held between reads so the answer stands until the next read
			if (mgmt_rd_in)
			begin
				unique case (sel)
					ANR_SEL_STATUS: mgmt_rdata_out <= negotiation_status_reg;
					ANR_SEL_ADVERT: mgmt_rdata_out <= local_advert_low_reg;
					default: mgmt_rdata_out <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Access steps shared by the checks
	sequence status_access_s;
		mgmt_rd_in && sel == ANR_SEL_STATUS;
	endsequence

	sequence advert_access_s;
		mgmt_rd_in && sel == ANR_SEL_ADVERT;
	endsequence

	sequence unmapped_access_s;
		mgmt_rd_in && sel == ANR_SEL_NONE;
	endsequence

	sequence advert_store_s;
		mgmt_wr_in && sel == ANR_SEL_ADVERT;
	endsequence

	sequence store_then_next_s;
		advert_store_s ##1 1'b1;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	// Status register checks
	done_cause_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		negotiation_done_flag |-> link_up_in && negotiation_finished_in && base_seen)
		else $error("complete without its causes");
	done_off_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!negotiation_enable_in |-> !negotiation_done_flag)
		else $error("complete set while disabled");
	done_disabled_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_rd && !negotiation_enable_in |=> !mgmt_rdata_out[`ANR_ST_DONE])
		else $error("complete read while disabled");
	status_fixed_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_access_s |=> mgmt_rdata_out[`ANR_ST_CAPABLE] && mgmt_rdata_out[15:7] == 9'h000
		&& mgmt_rdata_out[1:0] == 2'h0)
		else $error("status fixed bits wrong");
	page_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_access_s |=> mgmt_rdata_out[`ANR_ST_PAGE_RX] == $past(lf.page_received_flag))
		else $error("page flag not reported");
	page_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_rd && !codeword_captured_in |=> !lf.page_received_flag)
		else $error("page flag not cleared by read");
	fault_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_access_s |=> mgmt_rdata_out[`ANR_ST_FAULT] == $past(lf.partner_fault_flag))
		else $error("fault flag not reported");
	fault_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_rd && !codeword_captured_in |=> !lf.partner_fault_flag)
		else $error("fault flag not cleared by read");
	link_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_access_s |=> mgmt_rdata_out[`ANR_ST_LINK] == $past(lf.latched_link_up_flag))
		else $error("link flag not reported");
	done_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		status_access_s |=> mgmt_rdata_out[`ANR_ST_DONE] == $past(negotiation_done_flag))
		else $error("complete flag not reported");
	base_valid_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		codeword_captured_in && base_page_in && negotiation_enable_in |=> partner_page_valid_out)
		else $error("partner page not marked valid");
	base_keep_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		partner_page_valid_out && negotiation_enable_in |=> partner_page_valid_out)
		else $error("partner page valid lost while enabled");
	base_drop_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!negotiation_enable_in |=> !partner_page_valid_out)
		else $error("partner page valid kept while disabled");

	////////////////////////////////////////////////////////////////////////////
	// Advertisement register checks
	advert_fixed_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		advert_access_s |=> mgmt_rdata_out[4:0] == `ANR_SELECTOR && mgmt_rdata_out[9:5] == 5'h00)
		else $error("advert fixed bits wrong");
	advert_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		advert_store_s |=> next_page_request_out == $past(mgmt_wdata_in[`ANR_AD_NEXT_PAGE])
		&& local_fault_advert_out == $past(mgmt_wdata_in[`ANR_AD_FAULT]))
		else $error("advert write not stored");
	force_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		advert_store_s |=> role_force_select_out == $past(mgmt_wdata_in[`ANR_AD_FORCE]))
		else $error("force bit write not stored");
	pause_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		advert_store_s |=> pause_capability_out == $past(mgmt_wdata_in[`ANR_AD_PAUSE_HI:`ANR_AD_PAUSE_LO]))
		else $error("pause write not stored");
	advert_keep_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!advert_wr |=> $stable({next_page_request_out, local_fault_advert_out, role_force_select_out,
			pause_capability_out}))
		else $error("advert field changed without write");
	status_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		mgmt_wr_in && sel != ANR_SEL_ADVERT |=> $stable({next_page_request_out, local_fault_advert_out,
			role_force_select_out, pause_capability_out}))
		else $error("write elsewhere changed advert");
	ack_ro_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		store_then_next_s |-> codeword_ack == $past(codeword_ack_in))
		else $error("ack changed by write");
	ack_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		advert_access_s |=> mgmt_rdata_out[`ANR_AD_ACK] == $past(codeword_ack))
		else $error("ack bit not reported");
	advert_report_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		advert_access_s |=> mgmt_rdata_out[`ANR_AD_NEXT_PAGE] == $past(next_page_request_out)
		&& mgmt_rdata_out[`ANR_AD_FAULT] == $past(local_fault_advert_out)
		&& mgmt_rdata_out[`ANR_AD_FORCE] == $past(role_force_select_out)
		&& mgmt_rdata_out[`ANR_AD_PAUSE_HI:`ANR_AD_PAUSE_LO] == $past(pause_capability_out))
		else $error("advert read does not match fields");

	////////////////////////////////////////////////////////////////////////////
	// Read port checks
	read_valid_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		mgmt_rd_in |=> mgmt_rvalid_out)
		else $error("read not answered");
	rvalid_idle_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!mgmt_rd_in |=> !mgmt_rvalid_out)
		else $error("answer without read");
	rdata_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!mgmt_rd_in |=> $stable(mgmt_rdata_out))
		else $error("read data moved between reads");
	unmapped_zero_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		unmapped_access_s |=> mgmt_rdata_out == 16'h0000)
		else $error("unmapped read not zero");

	////////////////////////////////////////////////////////////////////////////
	// Reset values, checked one cycle after reset is high
	reset_values_a: assert property (@(posedge ref_clk_in)
		reset_in |=> !next_page_request_out && !local_fault_advert_out && !role_force_select_out
		&& pause_capability_out == 2'h0 && !codeword_ack && !mgmt_rvalid_out)
		else $error("advert fields not reset");
	reset_flags_a: assert property (@(posedge ref_clk_in)
		reset_in |=> !lf.page_received_flag && !lf.partner_fault_flag
		&& !lf.latched_link_up_flag && !base_seen)
		else $error("status flags not reset");
endmodule

/* design/anr_latch_flags.sv */
// Latched-high flags cleared and latched-low flag re-armed by a status read
`timescale 1ns/1ps
module anr_latch_flags
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	anr_latch_if.flags lf
);
	import anr_pkg::*;

	// Latched high: event wins over the read that clears
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			lf.page_received_flag <= 1'b0;
		else if (lf.page_event)
			lf.page_received_flag <= 1'b1;
		else if (lf.status_read)
			lf.page_received_flag <= 1'b0;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			lf.partner_fault_flag <= 1'b0;
		else if (lf.fault_event)
			lf.partner_fault_flag <= 1'b1;
		else if (lf.status_read)
			lf.partner_fault_flag <= 1'b0;
	end

	// Latched low: a drop wins over the read that re-arms
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			lf.latched_link_up_flag <= 1'b0;
		else if (!lf.link_now)
			lf.latched_link_up_flag <= 1'b0;
		else if (lf.status_read)
			lf.latched_link_up_flag <= 1'b1;
	end

	page_set_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		lf.page_event |=> lf.page_received_flag)
		else $error("page flag not set after capture");
	page_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		lf.page_received_flag && !lf.status_read |=> lf.page_received_flag)
		else $error("page flag dropped without read");
	fault_set_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		lf.fault_event |=> lf.partner_fault_flag)
		else $error("fault flag not latched");
	link_drop_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!lf.link_now |=> !lf.latched_link_up_flag)
		else $error("link flag not latched low");
	link_rearm_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		lf.status_read && lf.link_now |=> lf.latched_link_up_flag)
		else $error("link flag not re-armed by read");
endmodule

/* design/anr_latch_if.sv */
// Carrier between the bank and its latched status flags
`timescale 1ns/1ps
interface anr_latch_if;
	logic status_read;
	logic page_event;
	logic fault_event;
	logic link_now;
	logic page_received_flag;
	logic partner_fault_flag;
	logic latched_link_up_flag;
	modport bank
	(
		output status_read,
		output page_event,
		output fault_event,
		output link_now,
		input page_received_flag,
		input partner_fault_flag,
		input latched_link_up_flag
	);
	modport flags
	(
		input status_read,
		input page_event,
		input fault_event,
		input link_now,
		output page_received_flag,
		output partner_fault_flag,
		output latched_link_up_flag
	);
endinterface

/* design/anr_pkg.sv */
// Types shared by the negotiation register bank
package anr_pkg;
	typedef logic [15:0] anr_word_t;
	typedef enum logic [1:0] {
		ANR_SEL_NONE = 2'b00,
		ANR_SEL_STATUS = 2'b01,
		ANR_SEL_ADVERT = 2'b10
	} anr_sel_t;
endpackage

/* design/anr_regs.svh */
// Register offsets, field positions and reset values of the negotiation status/advert bank
`ifndef ANR_REGS_SVH
`define ANR_REGS_SVH
`define ANR_DEV_ADDR 5'h07
`define ANR_STATUS_OFS 16'h0201
`define ANR_ADVERT_OFS 16'h0202
`define ANR_STATUS_RESET 16'h0008
`define ANR_ADVERT_RESET 16'h0001
`define ANR_ST_PAGE_RX 6
`define ANR_ST_DONE 5
`define ANR_ST_FAULT 4
`define ANR_ST_CAPABLE 3
`define ANR_ST_LINK 2
`define ANR_AD_NEXT_PAGE 15
`define ANR_AD_ACK 14
`define ANR_AD_FAULT 13
`define ANR_AD_FORCE 12
`define ANR_AD_PAUSE_HI 11
`define ANR_AD_PAUSE_LO 10
`define ANR_SELECTOR 5'h01
`endif

/* dv/anr_host.sv */
// Host model issuing management reads and writes
`timescale 1ns/1ps
module anr_host
(
	input wire logic ref_clk_in,
	input wire logic mgmt_rvalid_in,
	input wire anr_pkg::anr_word_t mgmt_rdata_in,
	output logic [4:0] mgmt_dev_out,
	output logic [15:0] mgmt_addr_out,
	output logic mgmt_wr_out,
	output logic mgmt_rd_out,
	output anr_pkg::anr_word_t mgmt_wdata_out
);
	import anr_pkg::*;
	initial
	begin
		mgmt_dev_out = 5'h00;
		mgmt_addr_out = 16'h0000;
		mgmt_wr_out = 1'b0;
		mgmt_rd_out = 1'b0;
		mgmt_wdata_out = 16'h0000;
	end
	////////////////////////////////////////////////////////////
	// Strobes drop; device, address and write data lines show the inverse of their last value
	task automatic idle();
		mgmt_wr_out = 1'b0;
		mgmt_rd_out = 1'b0;
		mgmt_dev_out = ~mgmt_dev_out;
		mgmt_addr_out = ~mgmt_addr_out;
		mgmt_wdata_out = ~mgmt_wdata_out;
	endtask
	task automatic put(input logic [4:0] dev, input logic [15:0] addr);
		@(posedge ref_clk_in);
		#1;
		mgmt_dev_out = dev;
		mgmt_addr_out = addr;
	endtask
	task automatic write(input logic [4:0] dev, input logic [15:0] addr, input anr_word_t data);
		put(dev, addr);
		mgmt_wdata_out = data;
		mgmt_wr_out = 1'b1;
		@(posedge ref_clk_in);
		#1;
		idle();
	endtask
	task automatic read(input logic [4:0] dev, input logic [15:0] addr, output anr_word_t data, output logic ok);
		put(dev, addr);
		mgmt_rd_out = 1'b1;
		@(posedge ref_clk_in);
		#1;
		data = mgmt_rdata_in;
		ok = mgmt_rvalid_in;
		idle();
	endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the negotiation register bank
`timescale 1ns/1ps
module tb_top;
	import anr_pkg::*;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [4:0] mgmt_dev_in;
	logic [15:0] mgmt_addr_in;
	logic mgmt_wr_in;
	logic mgmt_rd_in;
	anr_word_t mgmt_wdata_in;
	anr_word_t mgmt_rdata_out;
	logic mgmt_rvalid_out;
	logic negotiation_enable_in = 1'b1;
	logic negotiation_finished_in = 1'b0;
	logic link_up_in = 1'b0;
	logic codeword_captured_in = 1'b0;
	logic base_page_in = 1'b0;
	logic partner_fault_in = 1'b0;
	logic codeword_ack_in = 1'b0;
	logic role_advert_in = 1'b0;
	logic next_page_request_out;
	logic local_fault_advert_out;
	logic role_force_select_out;
	logic [1:0] pause_capability_out;
	logic partner_page_valid_out;
	logic [1:0] role_mode_out;
	anr_word_t got;
	logic ok;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'h75F1B1C1;
	anr_bank u_anr_bank (.*);
	anr_host u_anr_host
	(
		.ref_clk_in(ref_clk_in),
		.mgmt_rvalid_in(mgmt_rvalid_out),
		.mgmt_rdata_in(mgmt_rdata_out),
		.mgmt_dev_out(mgmt_dev_in),
		.mgmt_addr_out(mgmt_addr_in),
		.mgmt_wr_out(mgmt_wr_in),
		.mgmt_rd_out(mgmt_rd_in),
		.mgmt_wdata_out(mgmt_wdata_in)
	);
	initial
	begin
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errors = errors + 1;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////
	function automatic anr_word_t st(input logic pg, input logic dn, input logic ft, input logic lk);
		return {9'h000, pg, dn, ft, 1'b1, lk, 2'h0};
	endfunction
	task automatic check(input anr_word_t a, input anr_word_t e);
		n_checks++;
		if (a !== e)
		begin
			errors++;
			$display("BAD %0t got %h want %h", $time, a, e);
		end
	endtask
	task automatic rd(input logic [4:0] d, input logic [15:0] a, input anr_word_t e);
		u_anr_host.read(d, a, got, ok);
		check({15'h0000, ok}, 16'h0001);
		check(got, e);
	endtask
	task automatic capture(input logic b, input logic f);
		base_page_in = b;
		partner_fault_in = f;
		codeword_captured_in = 1'b1;
		@(posedge ref_clk_in);
		#1 codeword_captured_in = 1'b0;
	endtask
	task automatic wrap_up();
		$display("Checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		anr_word_t w;
		repeat (10) @(posedge ref_clk_in);
		#1 reset_in = 1'b0;
		rd(5'h07, 16'h0201, 16'h0008);
		rd(5'h07, 16'h0202, 16'h0001);
		for (int i = 0; i < 10; i++)
		begin
			w = (i == 9) ? 16'hFFFF : 16'($random(seed));
			codeword_ack_in = ~w[14];
			role_advert_in = w[4];
			u_anr_host.write(5'h07, 16'h0202, w);
			rd(5'h07, 16'h0202, {w[15], ~w[14], w[13:10], 10'h001});
			check({11'h000, next_page_request_out, local_fault_advert_out, role_force_select_out,
				pause_capability_out}, {11'h000, w[15], w[13:10]});
			check({14'h0000, role_mode_out}, {14'h0000, w[12], w[4]});
		end
		u_anr_host.write(5'h06, 16'h0202, 16'h0000);
		u_anr_host.write(5'h07, 16'h0201, 16'hFFFF);
		rd(5'h07, 16'h0202, 16'hBC01);
		rd(5'h07, 16'h0201, 16'h0008);
		rd(5'h07, 16'h0203, 16'h0000);
		rd(5'h06, 16'h0201, 16'h0000);
		capture(1'b0, 1'b0);
		rd(5'h07, 16'h0201, st(1, 0, 0, 0));
		check({15'h0000, partner_page_valid_out}, 16'h0000);
		rd(5'h07, 16'h0201, st(0, 0, 0, 0));
		capture(1'b1, 1'b1);
		rd(5'h07, 16'h0201, st(1, 0, 1, 0));
		check({15'h0000, partner_page_valid_out}, 16'h0001);
		rd(5'h07, 16'h0201, st(0, 0, 0, 0));
		link_up_in = 1'b1;
		negotiation_finished_in = 1'b1;
		rd(5'h07, 16'h0201, st(0, 1, 0, 0));
		rd(5'h07, 16'h0201, st(0, 1, 0, 1));
		link_up_in = 1'b0;
		@(posedge ref_clk_in);
		#1 link_up_in = 1'b1;
		rd(5'h07, 16'h0201, st(0, 1, 0, 0));
		rd(5'h07, 16'h0201, st(0, 1, 0, 1));
		negotiation_enable_in = 1'b0;
		rd(5'h07, 16'h0201, st(0, 0, 0, 1));
		negotiation_enable_in = 1'b1;
		rd(5'h07, 16'h0201, st(0, 0, 0, 1));
		capture(1'b1, 1'b0);
		rd(5'h07, 16'h0201, st(1, 1, 0, 1));
		codeword_ack_in = 1'b0;
		reset_in = 1'b1;
		repeat (2) @(posedge ref_clk_in);
		#1 reset_in = 1'b0;
		rd(5'h07, 16'h0201, 16'h0008);
		rd(5'h07, 16'h0202, 16'h0001);
		wrap_up();
	end
endmodule
